// ---- rtl/eps_pkg.sv ----
// Shared types and constants of the execution-set issue block.
// Assumes a single core clock; consumers reference items as eps_pkg::name.
package eps_pkg;
   // ******************************
   // Widths and reset values
   // ******************************
   localparam int          PC_W      = 32;
   localparam int          DW        = 32;
   localparam int          NPTR      = 16;
   localparam int          WORD_W    = 16;          // Base word size
   localparam int          MAX_WORDS = 3;           // Base plus two extension words
   localparam logic [3:0]  BASE_OFS  = 4'h8;        // Base aliases sit on upper pointers
   localparam logic [31:0] PC_RST    = 32'h0000_0000;
   localparam logic [31:0] PTR_RST   = 32'h0000_0000;
   localparam logic        CARRY_RST = 1'b0;

   // ******************************
   // Enumerations and carriers
   // ******************************
   typedef enum logic [1:0] {K_ALU = 2'h0, K_AGU = 2'h1, K_MOVE = 2'h3, K_COF = 2'h2} eps_kind_t;
   typedef enum logic [1:0] {G_ALW = 2'h0, G_IFT = 2'h1, G_IFF = 2'h2} eps_grp_t;
   typedef enum logic [1:0] {A_UPD = 2'h0, A_NOUPD = 2'h1, A_PRE = 2'h2} eps_amode_t;

   typedef struct packed {
      logic              vld;
      eps_kind_t         kind;
      eps_grp_t          grp;     // Subgroup from the prefix
      eps_grp_t          ccond;   // Own condition of the instruction
      logic              carry;   // Carry-affecting
      logic              carry_v;
      logic              via_base; // Pointer named through its base alias
      logic [3:0]        preg;
      eps_amode_t        amode;
      logic [DW-1:0]     aval;    // Pointer result
      logic [3:0]        dreg;
      logic [DW-1:0]     data;
      logic [1:0]        words;
      logic              dly;     // Delayed change of flow
      logic [PC_W-1:0]   tgt;
   } eps_slot_t;

   typedef struct packed {
      logic              vld;
      logic [3:0]        reg_idx;
      logic [DW-1:0]     data;
   } eps_dwr_t;
endpackage

// ---- rtl/eps_issue.sv ----
// Issue, pointer update and commit logic for execution sets.
// Assumes the fetch side presents one decoded execution set per valid cycle.
// Overview of operation
// - No interlocks; ordering left to software
// - Instructions are one to three words
// - Base aliases share upper pointer storage
// - Delayed flow change runs one delay slot
// - Loop active exactly while its flag set
// - Pointers read and updated in address stage
// - Move-like data read and written in execute
// - Address-unit arithmetic completes in address stage
// - PC jumps only on flow, wrap, exception
// - Branch writes PC only if condition holds
// - Only true and false subgroups exclusive
// - Prefix words never occupy execution units
// - False set still takes one slot, cycle
// - Last executed carry writer sets carry
// - Sources sampled together, results committed together (carry commits one stage after pointers, move data)
`timescale 1ns/1ps
`default_nettype none

module eps_issue #(
   parameter int NSLOT = 6,
   parameter int NLOOP = 4
) (
   input  wire logic                          ref_clk_i,
   input  wire logic                          reset_n_i,
   input  wire logic                          set_vld_i,
   input  wire logic [1:0]                    pfx_words_i,
   input  wire eps_pkg::eps_slot_t            slot_i [NSLOT],
   input  wire logic                          t_flag_i,
   input  wire logic [NLOOP-1:0]              loop_enable_flag_i,
   input  wire logic [eps_pkg::PC_W-1:0]      loop_last_address_i [NLOOP],
   input  wire logic [eps_pkg::PC_W-1:0]      loop_start_address_i [NLOOP],
   input  wire logic                          exc_req_i,
   input  wire logic [eps_pkg::PC_W-1:0]      exc_vec_i,
   input  wire logic [3:0]                    ptr_rd_idx_i,
   output logic                               set_rdy_o,
   output logic [eps_pkg::PC_W-1:0]           pc_o,
   output logic                               carry_o,
   output logic [eps_pkg::DW-1:0]             ptr_rd_data_o,
   output eps_pkg::eps_dwr_t                  dwr_o [NSLOT],
   output logic                               err_o
);
   // ******************************
   // Elaboration checks
   // ******************************
   if (NSLOT < 1 || NSLOT > 8) begin : g_bad_nslot
      $error("NSLOT must be 1 to 8");
   end
   if (NLOOP < 1 || NLOOP > 4) begin : g_bad_nloop
      $error("NLOOP must be 1 to 4");
   end

   // ******************************
   // Condition decode
   // ******************************
   // Always-group is never exclusive with true or false groups
   function automatic logic grp_on(input eps_pkg::eps_grp_t g, input logic t);
      case (g)
         eps_pkg::G_IFT: grp_on = t;
         eps_pkg::G_IFF: grp_on = !t;
         default:        grp_on = 1'b1;
      endcase
   endfunction

   // Pointer index, folding the base alias onto the upper pointers
   function automatic logic [3:0] ptr_idx(input eps_pkg::eps_slot_t s);
      ptr_idx = s.via_base ? (eps_pkg::BASE_OFS | {1'b0, s.preg[2:0]}) : s.preg;
   endfunction

   logic [eps_pkg::NPTR-1:0][eps_pkg::DW-1:0] ptr_r, ptr_nxt;
   logic [eps_pkg::PC_W-1:0]                  pc_r, pc_nxt, tgt_r, tgt_nxt, seq_pc;
   logic                                      pend_r, pend_nxt;
   logic                                      carry_r, carry_nxt;
   logic                                      ex_cupd_r, ex_cupd_nxt, ex_cval_r, ex_cval_nxt;
   logic                                      ex_vld_r, ex_vld_nxt;
   eps_pkg::eps_dwr_t                         dwr_r [NSLOT];
   eps_pkg::eps_dwr_t                         dwr_nxt [NSLOT];
   logic                                      err_r, err_nxt;
   logic [NSLOT-1:0]                          en, ptr_we;
   logic [4:0]                                len;
   logic                                      bad_len, cof_take, cof_dly, wrap, all_noupd;
   logic [eps_pkg::PC_W-1:0]                  cof_tgt, wrap_pc;

   // ******************************
   // Address stage decode
   // ******************************
   // T is sampled once for the whole set so all slots see one value
   always_comb begin
      en        = '0;
      ptr_we    = '0;
      len       = {3'h0, pfx_words_i};
      bad_len   = 1'b0;
      cof_take  = 1'b0;
      cof_dly   = 1'b0;
      cof_tgt   = '0;
      all_noupd = 1'b1;
      ex_cupd_nxt = 1'b0;
      ex_cval_nxt = 1'b0;
      for (int i = 0; i < NSLOT; i++) begin
         en[i] = set_vld_i && slot_i[i].vld && grp_on(slot_i[i].grp, t_flag_i)
                 && grp_on(slot_i[i].ccond, t_flag_i);
         if (slot_i[i].vld) begin
            len = len + {3'h0, slot_i[i].words};
            bad_len = bad_len || (slot_i[i].words == 2'h0);
            all_noupd = all_noupd && slot_i[i].kind == eps_pkg::K_MOVE
                        && slot_i[i].amode != eps_pkg::A_UPD;
         end
         ptr_we[i] = en[i] && (slot_i[i].kind == eps_pkg::K_AGU
                     || (slot_i[i].kind == eps_pkg::K_MOVE
                     && slot_i[i].amode == eps_pkg::A_UPD));
         // Highest slot wins, matching encoder placement
         if (en[i] && slot_i[i].carry) begin
            ex_cupd_nxt = 1'b1;
            ex_cval_nxt = slot_i[i].carry_v;
         end
         if (en[i] && slot_i[i].kind == eps_pkg::K_COF) begin
            cof_take = 1'b1;
            cof_dly  = slot_i[i].dly;
            cof_tgt  = slot_i[i].tgt;
         end
      end
   end

   // ******************************
   // Loop wrap detection
   // ******************************
   // Innermost enabled loop (highest index) takes the wrap
   always_comb begin
      wrap    = 1'b0;
      wrap_pc = '0;
      for (int n = 0; n < NLOOP; n++) begin
         if (loop_enable_flag_i[n] && pc_r == loop_last_address_i[n]) begin
            wrap    = 1'b1;
            wrap_pc = loop_start_address_i[n];
         end
      end
   end

   // ******************************
   // Program counter and delay slot
   // ******************************
   // Sets issue every valid cycle; no hazard check by design
   always_comb begin
      seq_pc   = pc_r + eps_pkg::PC_W'(len);
      pc_nxt   = pc_r;
      pend_nxt = pend_r;
      tgt_nxt  = tgt_r;
      if (exc_req_i) begin
         pc_nxt   = exc_vec_i;
         pend_nxt = 1'b0;
      end else if (set_vld_i) begin
         if (pend_r) begin
            pc_nxt   = tgt_r;
            pend_nxt = 1'b0;
         end else if (cof_take && cof_dly) begin
            pc_nxt   = seq_pc;
            pend_nxt = 1'b1;
            tgt_nxt  = cof_tgt;
         end else if (cof_take) begin
            pc_nxt   = cof_tgt;
         end else if (wrap) begin
            pc_nxt   = wrap_pc;
         end else begin
            pc_nxt   = seq_pc;
         end
      end
   end

   // ******************************
   // Pointer file and execute stage
   // ******************************
   // Pointers and move data both register at the address-stage edge; carry one stage later
   always_comb begin
      ptr_nxt     = ptr_r;
      carry_nxt   = ex_cupd_r ? ex_cval_r : carry_r;
      ex_vld_nxt  = set_vld_i;
      err_nxt     = set_vld_i && bad_len;
      for (int i = 0; i < NSLOT; i++) begin
         if (ptr_we[i]) begin
            ptr_nxt[ptr_idx(slot_i[i])] = slot_i[i].aval;
         end
         dwr_nxt[i].vld     = en[i] && slot_i[i].kind == eps_pkg::K_MOVE;
         dwr_nxt[i].reg_idx = slot_i[i].dreg;
         dwr_nxt[i].data    = slot_i[i].data;
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ptr_r     <= {eps_pkg::NPTR{eps_pkg::PTR_RST}};
         pc_r      <= eps_pkg::PC_RST;
         tgt_r     <= eps_pkg::PC_RST;
         pend_r    <= 1'b0;
         carry_r   <= eps_pkg::CARRY_RST;
         ex_cupd_r <= 1'b0;
         ex_cval_r <= 1'b0;
         ex_vld_r  <= 1'b0;
         err_r     <= 1'b0;
         for (int i = 0; i < NSLOT; i++) begin
            dwr_r[i] <= '0;
         end
      end else begin
         ptr_r     <= ptr_nxt;
         pc_r      <= pc_nxt;
         tgt_r     <= tgt_nxt;
         pend_r    <= pend_nxt;
         carry_r   <= carry_nxt;
         ex_cupd_r <= ex_cupd_nxt;
         ex_cval_r <= ex_cval_nxt;
         ex_vld_r  <= ex_vld_nxt;
         err_r     <= err_nxt;
         for (int i = 0; i < NSLOT; i++) begin
            dwr_r[i] <= dwr_nxt[i];
         end
      end
   end

   // ******************************
   // Outputs
   // ******************************
   assign set_rdy_o     = 1'b1;
   assign pc_o          = pc_r;
   assign carry_o       = carry_r;
   assign ptr_rd_data_o = ptr_r[ptr_rd_idx_i];
   assign err_o         = err_r;
   assign dwr_o         = dwr_r;

   // ******************************
   // Assertions
   // ******************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_dly_issue;
      set_vld_i && !exc_req_i && !pend_r && cof_take && cof_dly;
   endsequence
   sequence s_slot_filled;
      pend_r && set_vld_i && !exc_req_i;
   endsequence

   property p_delay_slot;
      s_dly_issue |=> pend_r && pc_r == $past(seq_pc) ##0 s_slot_filled
         |=> !pend_r && pc_r == $past(tgt_r);
   endproperty
   a_delay_slot: assert property (p_delay_slot) else $error("delay slot order wrong");

   property p_seq_pc;
      set_vld_i && !exc_req_i && !pend_r && !cof_take && !wrap
         |=> pc_r == $past(pc_r) + eps_pkg::PC_W'($past(len));
   endproperty
   a_seq_pc: assert property (p_seq_pc) else $error("pc left sequence");

   property p_cof_false;
      set_vld_i && !exc_req_i && !pend_r && !wrap && slot_i[0].vld
         && slot_i[0].kind == eps_pkg::K_COF && !en[0]
         |=> pc_r == $past(seq_pc);
   endproperty
   a_cof_false: assert property (p_cof_false) else $error("untaken branch moved pc");

   property p_loop_wrap;
      set_vld_i && !exc_req_i && !pend_r && !cof_take && wrap |=> pc_r == $past(wrap_pc);
   endproperty
   a_loop_wrap: assert property (p_loop_wrap) else $error("loop did not wrap");

   property p_ptr_noupd;
      set_vld_i && all_noupd |=> $stable(ptr_r);
   endproperty
   a_ptr_noupd: assert property (p_ptr_noupd) else $error("no-update mode wrote pointer");

   property p_alias;
      ptr_we[0] && slot_i[0].via_base
         |=> ptr_r[eps_pkg::BASE_OFS | {1'b0, $past(slot_i[0].preg[2:0])}] == $past(slot_i[0].aval);
   endproperty
   a_alias: assert property (p_alias) else $error("alias missed upper pointer");

   property p_carry_keep;
      ex_vld_r && !ex_cupd_r |=> $stable(carry_r);
   endproperty
   a_carry_keep: assert property (p_carry_keep) else $error("carry changed without writer");

   property p_carry_last;
      set_vld_i && en[NSLOT-1] && slot_i[NSLOT-1].carry
         |-> ##2 carry_r == $past(slot_i[NSLOT-1].carry_v, 2);
   endproperty
   a_carry_last: assert property (p_carry_last) else $error("last carry writer lost");

   property p_no_stall;
      set_vld_i |-> set_rdy_o ##1 ex_vld_r;
   endproperty
   a_no_stall: assert property (p_no_stall) else $error("set not dispatched");

   property p_false_nop;
      set_vld_i && en == '0 |=> ex_vld_r && !dwr_r[0].vld && $stable(ptr_r);
   endproperty
   a_false_nop: assert property (p_false_nop) else $error("false set not a no-op");

   property p_move_exec;
      set_vld_i && en[0] && slot_i[0].kind == eps_pkg::K_MOVE
         |=> dwr_r[0].vld && dwr_r[0].data == $past(slot_i[0].data);
   endproperty
   a_move_exec: assert property (p_move_exec) else $error("move data not in execute");

endmodule // eps_issue

`default_nettype wire

// ---- tb/eps_issue_tb.sv ----
// Self-checking bench for the execution-set issue block.
// Assumes eps_pkg and eps_issue are compiled first; the bench drives every port.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   // ******************************
   // Signals and bench state
   // ******************************
   typedef struct packed {logic [31:0] pc; logic vld; logic [31:0] data; logic err;} eps_note_t;
   logic               ref_clk_i, reset_n_i, set_vld_i, t_flag_i, exc_req_i;
   logic               set_rdy_o, carry_o, err_o, nt, ne, cm;
   logic [1:0]         pfx_words_i, np;
   logic [3:0]         loop_enable_flag_i, ptr_rd_idx_i;
   logic [31:0]        lla [4], lsa [4], ptr_m [16];
   logic [31:0]        exc_vec_i, pc_o, ptr_rd_data_o, pc_m, rng, w;
   eps_pkg::eps_slot_t sl [6], nx [6];
   eps_pkg::eps_dwr_t  dwr_o [6];
   eps_pkg::eps_grp_t  g, c;
   eps_note_t          notes [$];
   int                 failures, cmp_count;

   eps_issue u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .set_vld_i(set_vld_i),
      .pfx_words_i(pfx_words_i), .slot_i(sl), .t_flag_i(t_flag_i),
      .loop_enable_flag_i(loop_enable_flag_i), .loop_last_address_i(lla),
      .loop_start_address_i(lsa), .exc_req_i(exc_req_i), .exc_vec_i(exc_vec_i),
      .ptr_rd_idx_i(ptr_rd_idx_i), .set_rdy_o(set_rdy_o), .pc_o(pc_o), .carry_o(carry_o),
      .ptr_rd_data_o(ptr_rd_data_o), .dwr_o(dwr_o), .err_o(err_o));

   // ******************************
   // Helpers
   // ******************************
   // Compare, count and report at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   function automatic logic en(input eps_pkg::eps_grp_t gg, input logic t);
      return (gg == eps_pkg::G_ALW) || (gg == eps_pkg::G_IFT && t) || (gg == eps_pkg::G_IFF && !t);
   endfunction

   // Set length: prefix words plus words of every valid slot
   function automatic logic [31:0] len();
      len = 32'(np);
      foreach (nx[i]) if (nx[i].vld) len += 32'(nx[i].words);
   endfunction

   // Next set holds one plain move in slot 0, no pointer write
   task automatic mv(input logic [31:0] d);
      foreach (nx[i]) nx[i] = '0;
      np = 2'h0;
      ne = 1'b0;
      nx[0].vld = 1'b1;
      nx[0].kind = eps_pkg::K_MOVE;
      nx[0].amode = eps_pkg::A_NOUPD;
      nx[0].words = 2'h1;
      nx[0].data = d;
   endtask

   // Drive the prepared set just after the edge and note what it must yield
   task automatic send(input logic [31:0] npc, input logic v, input logic [31:0] d);
      logic e;
      // Any valid slot claiming zero words must raise the length flag
      e = 1'b0;
      foreach (nx[i]) if (nx[i].vld && nx[i].words == 2'h0) e = 1'b1;
      @(posedge ref_clk_i);
      #1;
      sl = nx;
      t_flag_i = nt;
      pfx_words_i = np;
      exc_req_i = ne;
      set_vld_i = 1'b1;
      notes.push_back('{npc, v, d, e});
      pc_m = npc;
   endtask

   task automatic idle();
      @(posedge ref_clk_i);
      #1;
      set_vld_i = 1'b0;
      exc_req_i = 1'b0;
   endtask

   task automatic test_done();
      $display("Comparisons %0d, failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ******************************
   // Clock, watchdog, monitor
   // ******************************
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // Run needs about 120 cycles; the 2500-cycle limit means a hang
   initial begin
      #100000;
      failures++;
      $display("MISMATCH %0t watchdog expired", $time);
      test_done();
   end

   // Every taken set answers one edge later on pc, slot 0 write and length flag
   always @(posedge ref_clk_i) begin
      if (set_vld_i === 1'b1 && reset_n_i === 1'b1) begin
         eps_note_t n;
         #2;
         n = notes.pop_front();
         chk(pc_o, n.pc, "pc");
         chk({31'h0, dwr_o[0].vld}, {31'h0, n.vld}, "write valid");
         chk({31'h0, err_o}, {31'h0, n.err}, "length error");
         if (n.vld) chk(dwr_o[0].data, n.data, "write data");
      end
   end

   // ******************************
   // Main sequence
   // ******************************
   initial begin
      reset_n_i = 1'b0;
      set_vld_i = 1'b0;
      t_flag_i = 1'b0;
      nt = 1'b0;
      cm = 1'b0;
      exc_vec_i = 32'h0000_0400;
      ptr_rd_idx_i = 4'h0;
      loop_enable_flag_i = 4'h0;
      rng = 32'h3CE7;
      failures = 0;
      cmp_count = 0;
      pc_m = 32'h0;
      foreach (ptr_m[i]) ptr_m[i] = 32'h0;
      foreach (lla[i]) lla[i] = 32'hFFFF_FFF0;
      foreach (lsa[i]) lsa[i] = 32'h0;
      mv(32'h0);
      sl = nx;
      pfx_words_i = 2'h0;
      exc_req_i = 1'b0;
      repeat (8) @(posedge ref_clk_i);
      #1;
      reset_n_i = 1'b1;
      chk(pc_o, 32'h0, "pc reset");
      chk({31'h0, set_rdy_o}, 32'h1, "ready");
      // Back-to-back sets: random lengths, prefixes, pointer updates via alias
      for (int k = 0; k < 24; k++) begin
         w = xs();
         mv(xs());
         np = w[10:9];
         nx[0].via_base = w[3];
         nx[0].preg = {1'b0, w[6:4]};
         nx[0].amode = eps_pkg::eps_amode_t'(2'(w[2:1] % 3));
         nx[0].aval = xs();
         nx[0].words = 2'(w[8:7] % 3 + 1);
         nx[1] = nx[0];
         nx[1].kind = eps_pkg::K_AGU;
         nx[1].via_base = 1'b0;
         nx[1].preg = 4'(w[13:11]);
         nx[1].aval = xs();
         if (nx[0].amode == eps_pkg::A_UPD) ptr_m[w[6:4] + (w[3] ? 8 : 0)] = nx[0].aval;
         ptr_m[w[13:11]] = nx[1].aval;
         send(pc_m + len(), 1'b1, nx[0].data);
      end
      idle();
      for (int i = 0; i < 16; i++) begin
         ptr_rd_idx_i = 4'(i);
         #1;
         chk(ptr_rd_data_o, ptr_m[i], "pointer");
      end
      // Every subgroup and own condition against both flag states, with carry
      for (int i = 0; i < 18; i++) begin
         w = xs();
         mv(w);
         nt = i[0];
         g = eps_pkg::eps_grp_t'(2'(i / 6));
         c = eps_pkg::eps_grp_t'(2'((i / 2) % 3));
         nx[0].grp = g;
         nx[0].ccond = c;
         nx[1].vld = 1'b1;
         nx[1].kind = eps_pkg::K_ALU;
         nx[1].words = 2'h1;
         nx[1].carry = w[1];
         nx[1].carry_v = w[2];
         nx[5] = nx[1];
         nx[5].grp = g;
         nx[5].ccond = c;
         nx[5].carry = 1'b1;
         nx[5].carry_v = w[3];
         if (en(g, nt) && en(c, nt)) cm = w[3];
         else if (w[1]) cm = w[2];
         send(pc_m + len(), en(g, nt) && en(c, nt), w);
         idle();
         idle();
         chk({31'h0, carry_o}, {31'h0, cm}, "carry");
      end
      // Plain and delayed branch in slot 0, taken and not, each followed at once by a set
      for (int i = 0; i < 4; i++) begin
         w = xs() & 32'h0000_FFFE;
         mv(w);
         nt = i[0];
         nx[1] = nx[0];
         nx[0].kind = eps_pkg::K_COF;
         nx[0].grp = eps_pkg::G_IFT;
         nx[0].words = 2'h2;
         nx[0].dly = i[1];
         nx[0].tgt = w;
         send((nt && !i[1]) ? w : pc_m + len(), 1'b0, w);
         mv(~w);
         send((nt && i[1]) ? w : pc_m + len(), 1'b1, ~w);
         idle();
      end
      // Loop wrap at last address, taken only while that loop is enabled
      for (int j = 0; j < 8; j++) begin
         w = xs();
         mv(w);
         lla[j % 4] = pc_m;
         lsa[j % 4] = w & 32'h0000_FFFF;
         loop_enable_flag_i = (j < 4) ? (4'(1 << j) | w[3:0]) : ~4'(1 << (j - 4));
         send((j < 4) ? lsa[j % 4] : pc_m + len(), 1'b1, w);
         idle();
         lla[j % 4] = 32'hFFFF_FFF0;
         loop_enable_flag_i = 4'h0;
      end
      // A slot claiming zero words is flagged, yet the set still issues
      mv(32'h0000_0055);
      nx[0].words = 2'h0;
      send(pc_m + len(), 1'b1, 32'h0000_0055);
      // Exception redirect takes precedence over the sequential step
      mv(32'h0);
      nx[0].vld = 1'b0;
      np = 2'h1;
      ne = 1'b1;
      send(32'h0000_0400, 1'b0, 32'h0);
      idle();
      idle();
      test_done();
   end
endmodule // testbench

`default_nettype wire
